// ---- rtl/dma_bus_arbiter.sv ----
// bus ownership arbiter for two dma channels, an external master and nmi abort
// =========================================================
// Contract
// [RL1] priority field 11 puts external master above channels, 10 below.
// [RL2] upper priority bit clear: lower bit ignored, external master never granted.
// [RL3] top priority: external request suspends channel after current byte, then resume.
// [RL4] channel requests during external ownership served after, if still pending.
// [RL5] bottom priority: external grant only once all channel transfers finish.
// [RL6] granted external master keeps the bus until it withdraws its request.
// [RL7] abort feature enabled by control bit one, disabled by zero.
// [RL8] nmi fall during transfer sets flag, bus back to cpu at byte boundary.
// [RL9] abort decided at end of state 3; later edges allow one more byte.
// [RL10] nmi handler must write the flag clear command before returning.
// [RL11] request reasserted one bus cycle plus 1.5 clocks after clear write.
// [RL12] external request during cpu-owned nmi handling asks cpu for the bus.
// [RL13] nmi taken from dma: external master gets bus only at top priority.
// [RL14] ready input synchronised before use as wait.
// [RL15] low synchronised ready at a phase boundary makes that cycle a wait.
// [RL16] waits only in states 2 and 3 memory-memory, state 3 otherwise.
// [RL17] reset clears all state: counts zero, channels off, abort off; here abort enable is an input that reset does not clear.
// [RL18] reset abandons any transfer at once.
// [RL19] active channel acknowledge low for every type; address and strobe still out.
// [RL20] software should load base port address with an unused i/o address.
// [RL21] external request and grant are active low, request level sensitive.
// [RL22] channel 1 always wins over channel 0.
// [RL23] nmi synchronised and falling edge caught once per edge.
`timescale 1ns/10ps
module dma_bus_arbiter (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [1:0] ext_priority,
  input wire logic nmi_abort_enable,
  input wire logic [1:0] ch_start,
  input wire logic [1:0] ch_demand_mode,
  input wire logic [1:0] ch_xfer_mem_mem,
  input wire logic [dma_arb_pkg::COUNT_W-1:0] ch_byte_count,
  input wire logic [dma_arb_pkg::PORT_W-1:0] base_port_address_zero,
  input wire logic [dma_arb_pkg::PORT_W-1:0] base_port_address_one,
  input wire logic channel_zero_request,
  input wire logic channel_one_request,
  input wire logic external_master_bus_request_n,
  input wire logic nmi_n,
  input wire logic external_ready_wait,
  input wire logic nmi_flag_clear_command,
  input wire logic cpu_bus_grant,
  output logic cpu_bus_request,
  output logic external_master_bus_grant_n,
  output logic [1:0] dma_acknowledge_n,
  output logic port_address_latch_strobe,
  output logic [dma_arb_pkg::PORT_W-1:0] port_address,
  output logic [1:0] terminal_count,
  output logic nmi_flag,
  output logic [1:0] bus_owner
);
  // =========================================================
  // pin synchronisation
  pin_sync_if pins ();

  // [RL14] ready, request and nmi pass the agreement synchroniser
  pin_sync u_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .raw_pins({external_ready_wait, external_master_bus_request_n, nmi_n}),
    .sync(pins)
  );

  logic nmi_s;
  logic ext_req;
  logic wait_s;
  assign nmi_s = pins.level[dma_arb_pkg::PIN_NMI];
  // [RL21] request is active low and taken as a level
  assign ext_req = !pins.level[dma_arb_pkg::PIN_EXT];
  assign wait_s = !pins.level[dma_arb_pkg::PIN_RDY];

  // =========================================================
  // state
  dma_arb_pkg::owner_e owner_q;
  dma_arb_pkg::phase_e phase_q;
  logic target_ext_q;
  logic act_ch_q;
  logic stop_q;
  logic nmi_prev_q;
  logic nmi_from_dma_q;
  logic [dma_arb_pkg::RESUME_W-1:0] resume_q;
  logic [1:0] running_q;
  logic [1:0] single_q;
  logic [1:0] req_prev_q;
  logic [dma_arb_pkg::COUNT_W-1:0] count_q [2];

  // =========================================================
  // decode of configuration and requests
  logic [1:0] ch_req;
  logic [1:0] pend;
  logic any_pend;
  logic sel_ch;
  logic ext_allowed;
  logic ext_top;
  logic nmi_fall;
  logic nmi_block;
  logic dma_want;
  logic byte_start;
  logic byte_end;
  logic hold_wait;
  logic ext_from_cpu;
  logic ext_from_dma;

  assign ch_req = {channel_one_request, channel_zero_request};
  // [RL2] without the upper bit the external master is never served
  assign ext_allowed = ext_priority[dma_arb_pkg::PRIO_USE_BIT];
  // [RL1] top when the field reads 11, bottom when 10
  assign ext_top = (ext_priority == dma_arb_pkg::PRIO_TOP);
  // [RL23] edge taken from the filtered level, never the first stage
  assign nmi_fall = nmi_prev_q && !nmi_s;
  // [RL7] abort only acts while enabled
  assign nmi_block = nmi_abort_enable && (nmi_flag || (resume_q != dma_arb_pkg::RESUME_IDLE));
  assign any_pend = |pend;
  // [RL22] channel 1 beats channel 0
  assign sel_ch = pend[1];
  assign dma_want = any_pend && !nmi_block;
  // [RL13] after an abort from dma, only a top priority master may cut in
  assign ext_from_cpu = ext_allowed && ext_req && (ext_top || !dma_want)
    && (ext_top || !nmi_from_dma_q);
  // [RL5] bottom priority waits for the channels to run dry
  assign ext_from_dma = ext_allowed && ext_req && (ext_top || !any_pend);

  // [RL16] waits in two only for memory-memory, always in three
  always_comb begin
    hold_wait = 1'b0;
    if (phase_q == dma_arb_pkg::PH_THREE) begin
      hold_wait = wait_s;
    end else if (phase_q == dma_arb_pkg::PH_TWO) begin
      hold_wait = wait_s && ch_xfer_mem_mem[act_ch_q];
    end
  end

  assign byte_end = (phase_q == dma_arb_pkg::PH_THREE) && !hold_wait;
  assign byte_start = (owner_q == dma_arb_pkg::OWN_DMA) && (phase_q == dma_arb_pkg::PH_IDLE)
    && !stop_q && !ext_from_dma && dma_want;

  // =========================================================
  // per channel request bookkeeping
  genvar c;
  generate
    for (c = 0; c < dma_arb_pkg::CH_N; c++) begin : g_ch
      // memory-memory runs to terminal count, demand follows the level
      assign pend[c] = running_q[c] && (ch_xfer_mem_mem[c] || (ch_demand_mode[c] ?
        ch_req[c] : single_q[c]));

      // [RL4] single requests are remembered across external ownership
      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          single_q[c] <= 1'b0;
          req_prev_q[c] <= 1'b0;
        end else begin
          req_prev_q[c] <= ch_req[c];
          if (running_q[c] && ch_req[c] && !req_prev_q[c]) begin
            single_q[c] <= 1'b1;
          end else if (byte_start && (sel_ch == 1'(c))) begin
            single_q[c] <= 1'b0;
          end else if (!running_q[c]) begin
            single_q[c] <= 1'b0;
          end
        end
      end

      // [RL17] counts clear to zero and channels stay off until started
      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          running_q[c] <= 1'b0;
          count_q[c] <= dma_arb_pkg::COUNT_RESET;
          terminal_count[c] <= 1'b0;
        end else begin
          terminal_count[c] <= 1'b0;
          if (ch_start[c]) begin
            running_q[c] <= 1'b1;
            count_q[c] <= ch_byte_count;
          end else if (byte_end && (act_ch_q == 1'(c))) begin
            count_q[c] <= count_q[c] - dma_arb_pkg::COUNT_LAST;
            if (count_q[c] == dma_arb_pkg::COUNT_LAST) begin
              running_q[c] <= 1'b0;
              terminal_count[c] <= 1'b1;
            end
          end
        end
      end
    end
  endgenerate

  // =========================================================
  // nmi flag and resume delay
  // [RL8] flag is sticky; a new edge wins over a clear in the same cycle
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      nmi_prev_q <= 1'b1;
      nmi_flag <= 1'b0;
    end else begin
      nmi_prev_q <= nmi_s;
      if (nmi_fall && nmi_abort_enable) begin
        nmi_flag <= 1'b1;
      end else if (nmi_flag_clear_command) begin
        nmi_flag <= 1'b0;
      end
    end
  end

  // [RL11] hold the channels back for a bus cycle and one and a half clocks
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      resume_q <= dma_arb_pkg::RESUME_IDLE;
    end else if (nmi_flag_clear_command) begin
      resume_q <= dma_arb_pkg::RESUME_LOAD;
    end else if (resume_q != dma_arb_pkg::RESUME_IDLE) begin
      resume_q <= resume_q - 1'b1;
    end
  end

  // [RL13] remember whether the abort took the bus from a channel
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      nmi_from_dma_q <= 1'b0;
    end else if (owner_q == dma_arb_pkg::OWN_DMA && phase_q == dma_arb_pkg::PH_IDLE
      && stop_q) begin
      nmi_from_dma_q <= 1'b1;
    end else if (nmi_flag_clear_command) begin
      nmi_from_dma_q <= 1'b0;
    end
  end

  // [RL9] judged at the end of state three; later edges let one more byte run
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      stop_q <= 1'b0;
    end else if (byte_end) begin
      stop_q <= nmi_abort_enable && nmi_flag;
    end else if (owner_q != dma_arb_pkg::OWN_DMA) begin
      stop_q <= 1'b0;
    end
  end

  // =========================================================
  // bus ownership
  // [RL18] reset drops the bus and any byte in flight at once
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      owner_q <= dma_arb_pkg::OWN_CPU;
      target_ext_q <= 1'b0;
      cpu_bus_request <= 1'b0;
      external_master_bus_grant_n <= 1'b1;
    end else begin
      unique case (owner_q)
        dma_arb_pkg::OWN_CPU: begin
          // [RL12] an external request during nmi handling still asks the cpu
          if (ext_from_cpu || dma_want) begin
            owner_q <= dma_arb_pkg::OWN_REQ;
            target_ext_q <= ext_from_cpu;
            cpu_bus_request <= 1'b1;
          end
        end
        dma_arb_pkg::OWN_REQ: begin
          if (cpu_bus_grant) begin
            if (target_ext_q) begin
              owner_q <= dma_arb_pkg::OWN_EXT;
              external_master_bus_grant_n <= 1'b0;
            end else begin
              owner_q <= dma_arb_pkg::OWN_DMA;
            end
          end
        end
        dma_arb_pkg::OWN_DMA: begin
          // [RL3] top priority cuts in only between bytes
          if (phase_q == dma_arb_pkg::PH_IDLE && !byte_start) begin
            if (ext_from_dma && !stop_q) begin
              owner_q <= dma_arb_pkg::OWN_EXT;
              external_master_bus_grant_n <= 1'b0;
            end else begin
              owner_q <= dma_arb_pkg::OWN_CPU;
              cpu_bus_request <= 1'b0;
            end
          end
        end
        dma_arb_pkg::OWN_EXT: begin
          // [RL6] nobody else gets the bus until the request is withdrawn
          if (!ext_req) begin
            external_master_bus_grant_n <= 1'b1;
            if (dma_want) begin
              owner_q <= dma_arb_pkg::OWN_DMA;
            end else begin
              owner_q <= dma_arb_pkg::OWN_CPU;
              cpu_bus_request <= 1'b0;
            end
          end
        end
      endcase
    end
  end

  assign bus_owner = owner_q;

  // =========================================================
  // byte phases and pin outputs
  // [RL15] a low ready holds state three, or state two of a memory-memory byte, for every cycle that it stays low
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      phase_q <= dma_arb_pkg::PH_IDLE;
      act_ch_q <= 1'b0;
    end else begin
      unique case (phase_q)
        dma_arb_pkg::PH_IDLE: begin
          if (byte_start) begin
            phase_q <= dma_arb_pkg::PH_ONE;
            act_ch_q <= sel_ch;
          end
        end
        dma_arb_pkg::PH_ONE: phase_q <= dma_arb_pkg::PH_TWO;
        dma_arb_pkg::PH_TWO: begin
          if (!hold_wait) begin
            phase_q <= dma_arb_pkg::PH_THREE;
          end
        end
        dma_arb_pkg::PH_THREE: begin
          if (!hold_wait) begin
            phase_q <= dma_arb_pkg::PH_IDLE;
          end
        end
      endcase
    end
  end

  // [RL19] acknowledge, port address and strobe go out for every type
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      dma_acknowledge_n <= dma_arb_pkg::ACK_IDLE;
      port_address_latch_strobe <= 1'b0;
      port_address <= dma_arb_pkg::PORT_RESET;
    end else begin
      if (byte_start) begin
        dma_acknowledge_n <= sel_ch ? 2'h1 : 2'h2;
        port_address_latch_strobe <= 1'b1;
        port_address <= sel_ch ? base_port_address_one : base_port_address_zero;
      end else if (phase_q == dma_arb_pkg::PH_ONE) begin
        port_address_latch_strobe <= 1'b0;
      end else if (byte_end) begin
        dma_acknowledge_n <= dma_arb_pkg::ACK_IDLE;
      end
    end
  end

  // =========================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  // [RL2] unused external master
  no_ext_grant_a: assert property (!ext_allowed && external_master_bus_grant_n
    |=> external_master_bus_grant_n)
    else $error("external grant while priority field unused");

  // [RL3] top priority preemption
  top_preempt_a: assert property (owner_q == dma_arb_pkg::OWN_DMA && byte_end && ext_top
    && ext_req && !nmi_block ##1 ext_req |=> !external_master_bus_grant_n)
    else $error("top priority master not granted after byte");

  // [RL5] bottom waits for channels
  bottom_wait_a: assert property ($fell(external_master_bus_grant_n)
    && $past(owner_q) == dma_arb_pkg::OWN_DMA && !$past(ext_top) |-> !$past(any_pend))
    else $error("bottom priority master granted with channel pending");

  // [RL6] external ownership holds
  ext_hold_a: assert property (owner_q == dma_arb_pkg::OWN_EXT && ext_req
    |=> owner_q == dma_arb_pkg::OWN_EXT && !external_master_bus_grant_n)
    else $error("bus taken from external master");

  // [RL8] abort returns bus at boundary
  nmi_release_a: assert property (byte_end && nmi_abort_enable && nmi_flag
    |-> ##2 owner_q == dma_arb_pkg::OWN_CPU && !cpu_bus_request)
    else $error("bus not returned after nmi abort");

  // [RL11] resume delay after clear
  resume_delay_a: assert property (nmi_flag_clear_command && nmi_abort_enable
    && owner_q == dma_arb_pkg::OWN_CPU && !ext_req |-> !cpu_bus_request [*5])
    else $error("request reasserted too early after clear");

  // [RL16] no wait in two outside memory-memory
  wait_phase_a: assert property (phase_q == dma_arb_pkg::PH_TWO
    && !ch_xfer_mem_mem[act_ch_q] |=> phase_q == dma_arb_pkg::PH_THREE)
    else $error("wait taken in state two of i/o transfer");

  // [RL15] wait holds state three
  wait_three_a: assert property (phase_q == dma_arb_pkg::PH_THREE && wait_s
    |=> phase_q == dma_arb_pkg::PH_THREE && dma_acknowledge_n != dma_arb_pkg::ACK_IDLE)
    else $error("wait not honoured in state three");

  // [RL22] channel one first
  ch_one_first_a: assert property (byte_start && pend[1] |=> act_ch_q && !dma_acknowledge_n[1])
    else $error("channel zero chosen over channel one");

  // [RL23] one flag set per edge
  nmi_once_a: assert property (nmi_fall && nmi_abort_enable |=> nmi_flag && !nmi_fall)
    else $error("nmi edge not captured once");
endmodule : dma_bus_arbiter

// ---- include/dma_arb_pkg.sv ----
// constants, state types and timing figures for the dma bus arbiter
package dma_arb_pkg;
  // =========================================================
  // widths and channel count
  localparam int CH_N = 2;
  localparam int PORT_W = 8;
  localparam int COUNT_W = 8;
  localparam int RESUME_W = 4;
  localparam int PIN_N = 3;

  // =========================================================
  // synchronised pin slots
  localparam int PIN_NMI = 0;
  localparam int PIN_EXT = 1;
  localparam int PIN_RDY = 2;
  localparam logic [PIN_N-1:0] PIN_RESET = 3'h7;

  // =========================================================
  // external master priority field, two bits of dma_control_two
  localparam logic [1:0] PRIO_TOP = 2'h3;
  localparam logic [1:0] PRIO_BOTTOM = 2'h2;
  localparam int PRIO_USE_BIT = 1;

  // =========================================================
  // reset values and the last count
  localparam logic [COUNT_W-1:0] COUNT_RESET = 8'h00;
  localparam logic [PORT_W-1:0] PORT_RESET = 8'h00;
  localparam logic [CH_N-1:0] ACK_IDLE = 2'h3;
  localparam logic [CH_N-1:0] CH_NONE = 2'h0;
  localparam logic [COUNT_W-1:0] COUNT_LAST = 8'h01;
  localparam logic [RESUME_W-1:0] RESUME_IDLE = 4'h0;

  // =========================================================
  // timing: resume one bus cycle plus 1.5 clocks after the clear write
  localparam int CLK_NS = 100;
  localparam int BUS_CYCLE_NS = 300;
  localparam int RESUME_CLK_TENTHS = 15;
  localparam int RESUME_NS = BUS_CYCLE_NS + (RESUME_CLK_TENTHS * CLK_NS) / 10;
  localparam int RESUME_CYC = (RESUME_NS + CLK_NS - 1) / CLK_NS;
  // one cycle is spent raising the request itself
  localparam logic [RESUME_W-1:0] RESUME_LOAD = RESUME_W'(RESUME_CYC - 1);

  // =========================================================
  // types
  typedef enum logic [1:0] {
    XFER_MEM_MEM = 2'b00,
    XFER_MEM_IO = 2'b01,
    XFER_IO_MEM = 2'b10
  } xfer_e;

  typedef enum logic [1:0] {
    OWN_CPU = 2'b00,
    OWN_REQ = 2'b01,
    OWN_DMA = 2'b10,
    OWN_EXT = 2'b11
  } owner_e;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_ONE = 2'b01,
    PH_TWO = 2'b10,
    PH_THREE = 2'b11
  } phase_e;
endpackage : dma_arb_pkg

// ---- include/pin_sync_if.sv ----
// synchronised pin levels passed from the synchroniser to the arbiter
`timescale 1ns/10ps
interface pin_sync_if;
  logic [dma_arb_pkg::PIN_N-1:0] level;
  modport src (output level);
  modport dst (input level);
endinterface : pin_sync_if

// ---- rtl/pin_sync.sv ----
// three-stage synchroniser with agreement filter for the asynchronous pins
`timescale 1ns/10ps
module pin_sync (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [dma_arb_pkg::PIN_N-1:0] raw_pins,
  pin_sync_if.src sync
);
  // =========================================================
  // per pin chain
  logic [dma_arb_pkg::PIN_N-1:0] s1_q;
  logic [dma_arb_pkg::PIN_N-1:0] s2_q;
  logic [dma_arb_pkg::PIN_N-1:0] s3_q;
  logic [dma_arb_pkg::PIN_N-1:0] lvl_q;

  genvar g;
  generate
    for (g = 0; g < dma_arb_pkg::PIN_N; g++) begin : g_pin
      // first stage feeds only the second; level moves when two and three agree
      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          s1_q[g] <= dma_arb_pkg::PIN_RESET[g];
          s2_q[g] <= dma_arb_pkg::PIN_RESET[g];
          s3_q[g] <= dma_arb_pkg::PIN_RESET[g];
          lvl_q[g] <= dma_arb_pkg::PIN_RESET[g];
        end else begin
          s1_q[g] <= raw_pins[g];
          s2_q[g] <= s1_q[g];
          s3_q[g] <= s2_q[g];
          if (s2_q[g] == s3_q[g]) begin
            lvl_q[g] <= s3_q[g];
          end
        end
      end
    end
  endgenerate

  assign sync.level = lvl_q;
endmodule : pin_sync

// ---- verif/cpu_bus_model.sv ----
// cpu side model that hands the bus over after a chosen delay
`timescale 1ns/10ps
module cpu_bus_model (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [3:0] delay,
  input wire logic cpu_bus_request,
  output logic cpu_bus_grant
);
  logic [3:0] cnt_q;
  // =========================================================
  // grant after delay cycles; a slow cpu finishes its own cycle first
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 4'h0;
      cpu_bus_grant <= 1'b0;
    end else if (!cpu_bus_request) begin
      cnt_q <= 4'h0;
      cpu_bus_grant <= 1'b0; // take the bus back at once
    end else if (cnt_q >= delay) begin
      cpu_bus_grant <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule : cpu_bus_model

// ---- verif/test_dma_bus_arbiter.sv ----
// self-checking bench for the dma bus arbiter
`timescale 1ns/10ps
module test_dma_bus_arbiter;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [1:0] ext_priority = 2'h0, ch_start = 2'h0, ch_mm = 2'h0;
  // base addresses stand for otherwise unused i/o ports
  logic [7:0] cnt = 8'h01, base0 = 8'h5A, base1 = 8'hA5;
  logic abort_en = 1'b0, req0 = 1'b0, req1 = 1'b0, ext_req_n = 1'b1;
  logic nmi_n = 1'b1, ready = 1'b1, clr = 1'b0, grant;
  logic [3:0] delay = 4'h0;
  logic bus_req, grant_n, strobe, flag;
  logic [1:0] ack_n, tc, owner;
  logic [7:0] port;
  int n_fail = 0;
  int tests_run = 0;

  always #50 core_clk = ~core_clk;

  dma_bus_arbiter i_dut (.core_clk(core_clk), .nrst(nrst), .ext_priority(ext_priority),
    .nmi_abort_enable(abort_en), .ch_start(ch_start), .ch_demand_mode(2'h0),
    .ch_xfer_mem_mem(ch_mm), .ch_byte_count(cnt), .base_port_address_zero(base0),
    .base_port_address_one(base1), .channel_zero_request(req0),
    .channel_one_request(req1), .external_master_bus_request_n(ext_req_n),
    .nmi_n(nmi_n), .external_ready_wait(ready), .nmi_flag_clear_command(clr),
    .cpu_bus_grant(grant), .cpu_bus_request(bus_req),
    .external_master_bus_grant_n(grant_n), .dma_acknowledge_n(ack_n),
    .port_address_latch_strobe(strobe), .port_address(port), .terminal_count(tc),
    .nmi_flag(flag), .bus_owner(owner));

  cpu_bus_model i_cpu (.core_clk(core_clk), .nrst(nrst), .delay(delay),
    .cpu_bus_request(bus_req), .cpu_bus_grant(grant));

  // =========================================================
  // helpers
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick

  // wide enough for every packed group of outputs compared below
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [1:0] cur(input int sel);
    case (sel)
      0: return owner;
      1: return ack_n;
      2: return tc;
      default: return {1'b0, grant_n};
    endcase
  endfunction : cur

  // bounded wait for one of the watched outputs
  task automatic wait_val(input int sel, input logic [1:0] v);
    int i;
    for (i = 0; i < 300 && cur(sel) !== v; i++) tick(1);
    if (i == 300) begin
      n_fail++;
      $display("BAD %0t wait %0d timed out", $time, sel);
      close_out();
    end
  endtask : wait_val

  task automatic start(input logic [1:0] ch, input logic [1:0] mm, input logic [7:0] n);
    ch_mm = mm;
    cnt = n;
    ch_start = ch;
    tick(1);
    ch_start = 2'h0;
  endtask : start

  // =========================================================
  // main sequence
  initial begin
    tick(3);
    nrst = 1'b1;
    chk({bus_req, grant_n, ack_n, strobe, tc, flag}, 16'h0070);
    chk({owner, port}, 8'h00);
    tick(6);
    // single byte: ack low, strobe and address out
    start(2'h1, 2'h0, 8'h01);
    req0 = 1'b1;
    wait_val(1, 2'b10);
    chk({strobe, port}, {1'b1, base0});
    wait_val(2, 2'b01);
    wait_val(0, 2'b00);
    req0 = 1'b0;
    // channel one first when both pend, slow cpu
    delay = 4'h3;
    start(2'h3, 2'h0, 8'h01);
    req0 = 1'b1;
    req1 = 1'b1;
    wait_val(0, 2'b10);
    for (int i = 0; i < 40 && tc === 2'b00; i++) tick(1);
    chk(tc, 2'b10);
    wait_val(2, 2'b01);
    wait_val(0, 2'b00);
    {req0, req1} = 2'b00;
    delay = 4'h0;
    // upper priority bit clear: never granted
    ext_req_n = 1'b0;
    tick(20);
    chk({grant_n, owner}, 8'h04);
    // top priority grants the external master
    ext_priority = dma_arb_pkg::PRIO_TOP;
    wait_val(3, 2'b00);
    chk(owner, 2'b11);
    // channel request while external master holds the bus
    start(2'h2, 2'h0, 8'h01);
    req1 = 1'b1;
    tick(10);
    chk({grant_n, ack_n, owner}, 8'h0F);
    ext_req_n = 1'b1;
    wait_val(2, 2'b10);
    wait_val(0, 2'b00);
    req1 = 1'b0;
    // top priority master cuts into a mem-mem run between bytes
    start(2'h1, 2'h1, 8'h08);
    wait_val(1, 2'b10);
    ext_req_n = 1'b0;
    wait_val(3, 2'b00);
    chk({owner, tc, ack_n}, 16'h0033);
    ext_req_n = 1'b1;
    wait_val(2, 2'b01);
    wait_val(0, 2'b00);
    // bottom priority waits for the whole mem-mem run
    ext_priority = dma_arb_pkg::PRIO_BOTTOM;
    start(2'h1, 2'h1, 8'h04);
    wait_val(0, 2'b10);
    ext_req_n = 1'b0;
    wait_val(2, 2'b01);
    chk(grant_n, 1'b1);
    wait_val(3, 2'b00);
    ext_req_n = 1'b1;
    wait_val(0, 2'b00);
    ext_priority = 2'h0;
    abort_en = 1'b1;
    start(2'h1, 2'h1, 8'h08);
    wait_val(1, 2'b10);
    nmi_n = 1'b0;
    tick(4);
    nmi_n = 1'b1;
    wait_val(0, 2'b00);
    tick(10);
    chk({flag, owner, tc}, 8'h10);
    // bottom master refused while the abort from dma is pending
    ext_priority = dma_arb_pkg::PRIO_BOTTOM;
    ext_req_n = 1'b0;
    tick(10);
    chk({flag, owner, tc, grant_n}, 16'h0021);
    ext_priority = 2'h0;
    ext_req_n = 1'b1;
    tick(6);
    // clear write, request back five edges later
    clr = 1'b1;
    tick(1);
    clr = 1'b0;
    tick(4);
    chk({flag, bus_req}, 8'h00);
    tick(1);
    chk(bus_req, 1'b1);
    wait_val(2, 2'b01);
    wait_val(0, 2'b00);
    // ready low stretches state 3 of a mem-io byte
    ready = 1'b0;
    start(2'h1, 2'h0, 8'h01);
    req0 = 1'b1;
    wait_val(1, 2'b10);
    tick(10);
    chk(ack_n, 2'b10);
    ready = 1'b1;
    wait_val(2, 2'b01);
    req0 = 1'b0;
    wait_val(0, 2'b00);
    start(2'h1, 2'h1, 8'h08);
    wait_val(1, 2'b10);
    nrst = 1'b0;
    tick(1);
    chk({bus_req, ack_n, owner}, 8'h0C);
    nrst = 1'b1;
    tick(5);
    close_out();
  end
endmodule : test_dma_bus_arbiter
